//--- verilog/isr_map.vh
/*
 Status reporting constants: register selectors, field positions, masks.
 Assumes inclusion by bare name from design files.
*/
`ifndef ISR_MAP_VH
`define ISR_MAP_VH
// ----------------------------------------
// Register selectors
// ----------------------------------------
`define ISR_SEL_STD_EVENT 4'h0
`define ISR_SEL_STD_ENABLE 4'h1
`define ISR_SEL_QUES_COND 4'h2
`define ISR_SEL_QUES_EVENT 4'h3
`define ISR_SEL_QUES_ENABLE 4'h4
`define ISR_SEL_CHAN_COND 4'h5
`define ISR_SEL_CHAN_EVENT 4'h6
`define ISR_SEL_CHAN_ENABLE 4'h7
`define ISR_SEL_LOAD_SUMMARY 4'h8
`define ISR_SEL_SUMMARY_ENABLE 4'h9
`define ISR_SEL_STATUS_BYTE 4'ha
`define ISR_SEL_SRQ_ENABLE 4'hb
// ----------------------------------------
// Standard event bits
// ----------------------------------------
`define ISR_SE_OPC 0
`define ISR_SE_QUERY 2
`define ISR_SE_DEVICE 3
`define ISR_SE_EXEC 4
`define ISR_SE_CMD 5
`define ISR_SE_PWRON 7
`define ISR_SE_USED 8'hbd
// ----------------------------------------
// Questionable / per-load bits
// ----------------------------------------
`define ISR_Q_VF 0
`define ISR_Q_OC 1
`define ISR_Q_OP 3
`define ISR_Q_OT 4
`define ISR_Q_OV 12
`define ISR_Q_PS 13
`define ISR_Q_USED 16'h301b
// ----------------------------------------
// Status byte bits and sizes
// ----------------------------------------
`define ISR_SB_CHAN 2
`define ISR_SB_QUES 3
`define ISR_SB_MSG 4
`define ISR_SB_EVT 5
`define ISR_SB_MSS 6
`define ISR_SB_OPER 7
`define ISR_SB_USED 8'hfc
`define ISR_NUM_LOADS 15
`define ISR_SUM_USED 16'h7fff
`endif

//--- verilog/isr_event_group.v
/*
 One condition/event/enable group: live condition, sticky event, gated summary.
 Assumes flags synchronous to core_clk; read clear is a one-cycle pulse.
*/
`timescale 1ns/100ps
`default_nettype none
module isr_event_group
(
    // Clock and reset
    input wire core_clk,
    input wire srst,
    // Condition in
    input wire [15:0] condIn,
    input wire [15:0] usedMask,
    // Control
    input wire readClear,
    input wire enableWrite,
    input wire [15:0] enableData,
    // State out
    output reg [15:0] eventFlags,
    output reg [15:0] enableMask,
    output wire summary
);
    reg [15:0] condLast;
    wire [15:0] rise;
    assign rise = condIn & ~condLast & usedMask;
    // ----------------------------------------
    // Event capture, set wins over clear
    // ----------------------------------------
    always @(posedge core_clk)
    begin
        if (srst)
        begin
            condLast <= 16'h0000;
            eventFlags <= 16'h0000;
            enableMask <= 16'h0000;
        end
        else
        begin
            condLast <= condIn;
            eventFlags <= (readClear ? 16'h0000 : eventFlags) | rise;
            if (enableWrite)
                enableMask <= enableData & usedMask;
        end
    end
    assign summary = |(eventFlags & enableMask);
endmodule
`default_nettype wire

//--- verilog/isr_status_top.v
/*
 Instrument status reporting: standard event, questionable, per-load and summary
 registers feeding a status byte with service request.
 Assumes command interpreter issues one-cycle read/write strobes on core_clk; fault
 inputs come from pins and are synchronised here.
*/
`timescale 1ns/100ps
`default_nettype none
`include "isr_map.vh"
// Contract
// - Bit 0 of standard event register flags completed pending operations.
// - Bit 7 sets after power-up and stays until read clears it.
// - Standard event bits 1 and 6 always read zero.
// - Questionable bits 0,1,3,4: voltage fault, overcurrent, overpower, overtemperature.
// - Questionable bit 12 overvoltage, bit 13 protection shutdown.
// - Questionable bits 2, 5..11, 14..15 always read zero.
// - One per-load register each, same bit layout as questionable.
// - Summary bit n is OR of load n; bit 15 reads zero.
// - Status byte selects service request sources; bit 6 is master summary.
// - Status byte bit 2 is OR of enabled summary bits.
// - Status byte bit 3 is OR of enabled questionable events.
// - Status byte bit 4 set while an error message waits.
// - Status byte bit 5 set when an enabled standard event occurs.
// - Status byte bit 7 set when an operation status event occurs.
// - Status byte bits 0 and 1 always read zero.
// - Registers 16 bits except standard event and status byte, 8 bits.
// - Event registers latch in real time, clear on read, enables gate summaries.
module isr_status_top
(
    // Clock and reset
    input wire core_clk,
    input wire srst,
    // Standard event sources, one-cycle pulses
    input wire opDone,
    input wire queryErr,
    input wire deviceErr,
    input wire execErr,
    input wire commandErr,
    // Queue and operation summaries
    input wire errorQueued,
    input wire operationSummary,
    // Fault pins per load, load 0 is master
    input wire [14:0] voltage_fault_flag,
    input wire [14:0] overcurrent_flag,
    input wire [14:0] overpower_flag,
    input wire [14:0] overtemperature_flag,
    input wire [14:0] overvoltage_flag,
    input wire [14:0] protection_shutdown_flag,
    // Register access
    input wire regRead,
    input wire regWrite,
    input wire [3:0] regSel,
    input wire [3:0] loadSel,
    input wire [15:0] regWdata,
    output reg [15:0] regRdata,
    // Service request
    output reg serviceRequest
);
    // ----------------------------------------
    // Register strobe decode
    // ----------------------------------------
    // Per-load strobes need a valid load index
    wire loadSelValid;
    wire stdEnableWrite;
    wire quesRead;
    wire quesEnableWrite;
    wire loadRead;
    wire loadEnableWrite;
    wire sumEnableWrite;
    wire srqEnableWrite;
    assign loadSelValid = (loadSel < 4'hf);
    assign stdEnableWrite = regWrite && (regSel == `ISR_SEL_STD_ENABLE);
    assign quesRead = regRead && (regSel == `ISR_SEL_QUES_EVENT);
    assign quesEnableWrite = regWrite && (regSel == `ISR_SEL_QUES_ENABLE);
    assign loadRead = regRead && (regSel == `ISR_SEL_CHAN_EVENT) && loadSelValid;
    assign loadEnableWrite = regWrite && (regSel == `ISR_SEL_CHAN_ENABLE) && loadSelValid;
    assign sumEnableWrite = regWrite && (regSel == `ISR_SEL_SUMMARY_ENABLE);
    assign srqEnableWrite = regWrite && (regSel == `ISR_SEL_SRQ_ENABLE);
    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    reg [89:0] faultMeta;
    reg [89:0] faultSync;
    wire [89:0] faultPins;
    wire [14:0] voltFaultSync;
    wire [14:0] overCurrSync;
    wire [14:0] overPowerSync;
    wire [14:0] overTempSync;
    wire [14:0] overVoltSync;
    wire [14:0] shutdownSync;
    assign faultPins = {protection_shutdown_flag,
                        overvoltage_flag,
                        overtemperature_flag,
                        overpower_flag,
                        overcurrent_flag,
                        voltage_fault_flag};
    assign voltFaultSync = faultSync[14:0];
    assign overCurrSync = faultSync[29:15];
    assign overPowerSync = faultSync[44:30];
    assign overTempSync = faultSync[59:45];
    assign overVoltSync = faultSync[74:60];
    assign shutdownSync = faultSync[89:75];
    always @(posedge core_clk)
    begin
        if (srst)
        begin
            faultMeta <= 90'h0;
            faultSync <= 90'h0;
        end
        else
        begin
            faultMeta <= faultPins;
            faultSync <= faultMeta;
        end
    end
    // ----------------------------------------
    // Standard event register
    // ----------------------------------------
    reg [7:0] stdEvent;
    reg [7:0] stdEnable;
    wire stdRead;
    wire [7:0] stdSet;
    assign stdRead = regRead && (regSel == `ISR_SEL_STD_EVENT);
    assign stdSet[`ISR_SE_OPC] = opDone;
    assign stdSet[1] = 1'b0;
    assign stdSet[`ISR_SE_QUERY] = queryErr;
    assign stdSet[`ISR_SE_DEVICE] = deviceErr;
    assign stdSet[`ISR_SE_EXEC] = execErr;
    assign stdSet[`ISR_SE_CMD] = commandErr;
    assign stdSet[6] = 1'b0;
    assign stdSet[`ISR_SE_PWRON] = 1'b0;
    always @(posedge core_clk)
    begin
        if (srst)
        begin
            stdEvent <= 8'h80;
        end
        else
        begin
            stdEvent <= ((stdRead ? 8'h00 : stdEvent) | stdSet) & `ISR_SE_USED;
        end
    end
    always @(posedge core_clk)
    begin
        if (srst)
        begin
            stdEnable <= 8'h00;
        end
        else if (stdEnableWrite)
        begin
            stdEnable <= regWdata[7:0] & `ISR_SE_USED;
        end
    end
    // ----------------------------------------
    // Per-load groups and questionable group
    // ----------------------------------------
    wire [15:0] loadCond [0:14];
    wire [15:0] loadEvent [0:14];
    wire [15:0] loadEnable [0:14];
    wire [14:0] loadSum;
    wire [15:0] loadSummary;
    wire [15:0] quesCond;
    wire [14:0] loadReadClear;
    wire [14:0] loadEnableStrobe;
    wire [15:0] condPick [0:14];
    wire [15:0] eventPick [0:14];
    wire [15:0] enablePick [0:14];
    genvar i;
    generate
        for (i = 0; i < `ISR_NUM_LOADS; i = i + 1)
        begin : gLoad
            localparam [3:0] LOAD_IDX = i;
            wire [15:0] cond;
            wire hit;
            assign cond[`ISR_Q_VF] = voltFaultSync[i];
            assign cond[`ISR_Q_OC] = overCurrSync[i];
            assign cond[2] = 1'b0;
            assign cond[`ISR_Q_OP] = overPowerSync[i];
            assign cond[`ISR_Q_OT] = overTempSync[i];
            assign cond[11:5] = 7'h00;
            assign cond[`ISR_Q_OV] = overVoltSync[i];
            assign cond[`ISR_Q_PS] = shutdownSync[i];
            assign cond[15:14] = 2'b00;
            assign loadCond[i] = cond;
            assign hit = (loadSel == LOAD_IDX);
            assign loadReadClear[i] = loadRead && hit;
            assign loadEnableStrobe[i] = loadEnableWrite && hit;
            isr_event_group uGroup
            (
                .core_clk(core_clk),
                .srst(srst),
                .condIn(loadCond[i]),
                .usedMask(`ISR_Q_USED),
                .readClear(loadReadClear[i]),
                .enableWrite(loadEnableStrobe[i]),
                .enableData(regWdata),
                .eventFlags(loadEvent[i]),
                .enableMask(loadEnable[i]),
                .summary(loadSum[i])
            );
            // Read select chain, only the addressed load contributes
            if (i == 0)
            begin : gFirst
                assign condPick[i] = hit ? loadCond[i] : 16'h0000;
                assign eventPick[i] = hit ? loadEvent[i] : 16'h0000;
                assign enablePick[i] = hit ? loadEnable[i] : 16'h0000;
            end
            else
            begin : gNext
                assign condPick[i] = condPick[i - 1] | (hit ? loadCond[i] : 16'h0000);
                assign eventPick[i] = eventPick[i - 1] | (hit ? loadEvent[i] : 16'h0000);
                assign enablePick[i] = enablePick[i - 1] | (hit ? loadEnable[i] : 16'h0000);
            end
        end
    endgenerate
    assign loadSummary = {1'b0, loadSum};
    // ----------------------------------------
    // Questionable group
    // ----------------------------------------
    // Unit level questionable is OR of all loads
    wire [15:0] quesOr [0:14];
    assign quesOr[0] = loadCond[0];
    generate
        for (i = 1; i < `ISR_NUM_LOADS; i = i + 1)
        begin : gOr
            assign quesOr[i] = quesOr[i - 1] | loadCond[i];
        end
    endgenerate
    assign quesCond = quesOr[14] & `ISR_Q_USED;
    wire [15:0] quesEvent;
    wire [15:0] quesEnable;
    wire quesSum;
    isr_event_group uQues
    (
        .core_clk(core_clk),
        .srst(srst),
        .condIn(quesCond),
        .usedMask(`ISR_Q_USED),
        .readClear(quesRead),
        .enableWrite(quesEnableWrite),
        .enableData(regWdata),
        .eventFlags(quesEvent),
        .enableMask(quesEnable),
        .summary(quesSum)
    );
    // ----------------------------------------
    // Status byte
    // ----------------------------------------
    reg [15:0] sumEnable;
    reg [7:0] srqEnable;
    wire [7:0] statusLow;
    wire [7:0] statusByte;
    wire masterSum;
    always @(posedge core_clk)
    begin
        if (srst)
        begin
            sumEnable <= 16'h0000;
        end
        else if (sumEnableWrite)
        begin
            sumEnable <= regWdata & `ISR_SUM_USED;
        end
    end
    always @(posedge core_clk)
    begin
        if (srst)
        begin
            srqEnable <= 8'h00;
        end
        else if (srqEnableWrite)
        begin
            srqEnable <= regWdata[7:0] & `ISR_SB_USED & 8'hbf;
        end
    end
    // ----------------------------------------
    // Status byte sources
    // ----------------------------------------
    wire chanAny;
    wire eventAny;
    wire [7:0] statusEnabled;
    assign chanAny = |(loadSummary & sumEnable);
    assign eventAny = |(stdEvent & stdEnable);
    assign statusLow[`ISR_SB_OPER] = operationSummary;
    assign statusLow[`ISR_SB_MSS] = 1'b0;
    assign statusLow[`ISR_SB_EVT] = eventAny;
    assign statusLow[`ISR_SB_MSG] = errorQueued;
    assign statusLow[`ISR_SB_QUES] = quesSum;
    assign statusLow[`ISR_SB_CHAN] = chanAny;
    assign statusLow[1:0] = 2'b00;
    assign statusEnabled = statusLow & srqEnable;
    assign masterSum = |statusEnabled;
    assign statusByte = statusLow | {1'b0, masterSum, 6'h00};
    // ----------------------------------------
    // Read mux and service request
    // ----------------------------------------
    // Unmapped selectors and load index 15 read zero
    reg [15:0] next_rdata;
    always @*
    begin
        next_rdata = 16'h0000;
        case (regSel)
            `ISR_SEL_STD_EVENT: next_rdata = {8'h00, stdEvent};
            `ISR_SEL_STD_ENABLE: next_rdata = {8'h00, stdEnable};
            `ISR_SEL_QUES_COND: next_rdata = quesCond;
            `ISR_SEL_QUES_EVENT: next_rdata = quesEvent;
            `ISR_SEL_QUES_ENABLE: next_rdata = quesEnable;
            `ISR_SEL_CHAN_COND: next_rdata = condPick[14];
            `ISR_SEL_CHAN_EVENT: next_rdata = eventPick[14];
            `ISR_SEL_CHAN_ENABLE: next_rdata = enablePick[14];
            `ISR_SEL_LOAD_SUMMARY: next_rdata = loadSummary;
            `ISR_SEL_SUMMARY_ENABLE: next_rdata = sumEnable;
            `ISR_SEL_STATUS_BYTE: next_rdata = {8'h00, statusByte};
            `ISR_SEL_SRQ_ENABLE: next_rdata = {8'h00, srqEnable};
            default: next_rdata = 16'h0000;
        endcase
    end
    always @(posedge core_clk)
    begin
        if (srst)
        begin
            regRdata <= 16'h0000;
        end
        else if (regRead)
        begin
            regRdata <= next_rdata;
        end
    end
    // ----------------------------------------
    // Service request output
    // ----------------------------------------
    always @(posedge core_clk)
    begin
        if (srst)
        begin
            serviceRequest <= 1'b0;
        end
        else
        begin
            serviceRequest <= masterSum;
        end
    end
endmodule
`default_nettype wire

//--- tb/isr_status_monitor.sv
/*
 Assertion checker for the status reporting block.
 Assumes binding to isr_status_top and its one-cycle register strobes.
*/
`timescale 1ns/100ps
`default_nettype none
module isr_status_monitor
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // Event sources
    input wire logic opDone,
    input wire logic queryErr,
    input wire logic deviceErr,
    input wire logic execErr,
    input wire logic commandErr,
    // Register access
    input wire logic regRead,
    input wire logic [3:0] regSel,
    input wire logic [15:0] regRdata
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);
    wire logic anyEv = opDone | queryErr | deviceErr | execErr | commandErr;
    // ----------------------------------------
    // Sequences and properties
    // ----------------------------------------
    sequence s_rdStd; regRead && regSel == 4'h0; endsequence
    sequence s_rdQuiet; regRead && regSel == 4'h0 && !anyEv; endsequence
    property p_opc; opDone ##1 !regRead ##1 s_rdStd |=> regRdata[0]; endproperty
    property p_cmd; commandErr ##1 !regRead ##1 s_rdStd |=> regRdata[5]; endproperty
    property p_stdZero;
        s_rdStd |=> regRdata[15:8] == 8'h00 && !regRdata[6] && !regRdata[1];
    endproperty
    property p_quesZero;
        regRead && (regSel == 4'h2 || regSel == 4'h3 || regSel == 4'h5 || regSel == 4'h6)
            |=> (regRdata & ~16'h301b) == 16'h0000;
    endproperty
    property p_sumTop; regRead && regSel == 4'h8 |=> !regRdata[15]; endproperty
    property p_sbZero;
        regRead && regSel == 4'ha |=> regRdata[1:0] == 2'h0 && regRdata[15:8] == 8'h00;
    endproperty
    property p_clear; s_rdQuiet ##1 !anyEv ##1 s_rdQuiet |=> regRdata == 16'h0000; endproperty
    property p_hold; !regRead |=> $stable(regRdata); endproperty
    a_opc: assert property (p_opc) else $error("done flag missing");
    a_cmd: assert property (p_cmd) else $error("command error flag missing");
    a_stdZero: assert property (p_stdZero) else $error("unused event bit set");
    a_quesZero: assert property (p_quesZero) else $error("unused fault bit set");
    a_sumTop: assert property (p_sumTop) else $error("summary bit 15 set");
    a_sbZero: assert property (p_sbZero) else $error("unused status bit set");
    a_clear: assert property (p_clear) else $error("event not cleared by read");
    a_hold: assert property (p_hold) else $error("read data moved");
endmodule
bind isr_status_top isr_status_monitor u_mon (.*);
`default_nettype wire

//--- tb/isr_host_model.sv
/*
 Host controller model issuing register reads and writes.
 Assumes the one-cycle strobe register contract on core_clk.
*/
`timescale 1ns/100ps
`default_nettype none
module isr_host_model
(
    // Clock
    input wire logic core_clk,
    // Register access
    output var logic regRead,
    output var logic regWrite,
    output var logic [3:0] regSel,
    output var logic [3:0] loadSel,
    output var logic [15:0] regWdata,
    input wire logic [15:0] regRdata
);
    initial
    begin
        regRead = 1'b0;
        regWrite = 1'b0;
        regSel = 4'h0;
        loadSel = 4'h0;
        regWdata = 16'h0000;
    end
    // One strobe, data taken after the edge; released data inverted
    task automatic xfer(input logic wr, input logic [3:0] sel, input logic [3:0] ld,
        input logic [15:0] wd, output logic [15:0] rd);
        @(posedge core_clk);
        regRead <= ~wr;
        regWrite <= wr;
        regSel <= sel;
        loadSel <= ld;
        regWdata <= wd;
        @(posedge core_clk);
        regRead <= 1'b0;
        regWrite <= 1'b0;
        regWdata <= ~wd;
        #1;
        rd = regRdata;
    endtask
endmodule
`default_nettype wire

//--- tb/instrument_status_reporting_tb_top.sv
/*
 Self-checking bench for the status reporting block.
 Assumes the host model drives the register strobes.
*/
`timescale 1ns/100ps
`default_nettype none
module instrument_status_reporting_tb_top;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic errorQueued = 1'b0;
    logic operationSummary = 1'b0;
    logic [4:0] ev = 5'h00;
    logic [14:0] voltage_fault_flag = 15'h0000;
    logic [14:0] overcurrent_flag = 15'h0000;
    logic [14:0] overpower_flag = 15'h0000;
    logic [14:0] overtemperature_flag = 15'h0000;
    logic [14:0] overvoltage_flag = 15'h0000;
    logic [14:0] protection_shutdown_flag = 15'h0000;
    wire logic opDone, queryErr, deviceErr, execErr, commandErr;
    wire logic regRead, regWrite, serviceRequest;
    wire logic [3:0] regSel, loadSel;
    wire logic [15:0] regWdata, regRdata;
    int n_fail = 0;
    int checks = 0;
    int cycles = 0;
    logic [15:0] junk;
    assign {commandErr, execErr, deviceErr, queryErr, opDone} = ev;
    isr_status_top dut_u (.*);
    isr_host_model u_host (.*);
    always #2 core_clk = ~core_clk;
    // ----------------------------------------
    // Checking helpers
    // ----------------------------------------
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task rdChk(input logic [3:0] sel, input logic [3:0] ld, input logic [15:0] exp);
        logic [15:0] d;
        u_host.xfer(1'b0, sel, ld, 16'h0000, d);
        chk(d, exp);
    endtask
    task wr(input logic [3:0] sel, input logic [3:0] ld, input logic [15:0] wd);
        u_host.xfer(1'b1, sel, ld, wd, junk);
    endtask
    task pulse(input logic [4:0] v);
        @(posedge core_clk);
        ev <= v;
        @(posedge core_clk);
        ev <= 5'h00;
    endtask
    task summarize;
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_reset;
        chk({15'h0000, serviceRequest}, 16'h0000);
        rdChk(4'h0, 4'h0, 16'h0080);
        rdChk(4'h0, 4'h0, 16'h0000);
        rdChk(4'hf, 4'h0, 16'h0000);
        rdChk(4'h5, 4'hf, 16'h0000);
    endtask
    task t_std;
        pulse(5'h1f);
        rdChk(4'h0, 4'h0, 16'h003d);
        wr(4'h1, 4'h0, 16'hffff);
        rdChk(4'h1, 4'h0, 16'h00bd);
        wr(4'h1, 4'h0, 16'h0000);
    endtask
    task t_fault;
        wr(4'h4, 4'h0, 16'hffff);
        wr(4'h7, 4'h3, 16'hffff);
        wr(4'h9, 4'h0, 16'hffff);
        wr(4'hb, 4'h0, 16'h00ff);
        rdChk(4'h4, 4'h0, 16'h301b);
        rdChk(4'h9, 4'h0, 16'h7fff);
        @(posedge core_clk);
        voltage_fault_flag <= 15'h0008;
        overcurrent_flag <= 15'h0008;
        overpower_flag <= 15'h0008;
        overtemperature_flag <= 15'h0008;
        overvoltage_flag <= 15'h0008;
        protection_shutdown_flag <= 15'h0008;
        repeat (6) @(posedge core_clk);
        rdChk(4'h2, 4'h0, 16'h301b);
        rdChk(4'h5, 4'h3, 16'h301b);
        rdChk(4'h5, 4'h0, 16'h0000);
        rdChk(4'h8, 4'h0, 16'h0008);
        rdChk(4'ha, 4'h0, 16'h004c);
        chk({15'h0000, serviceRequest}, 16'h0001);
        rdChk(4'h3, 4'h0, 16'h301b);
        rdChk(4'h3, 4'h0, 16'h0000);
        rdChk(4'ha, 4'h0, 16'h0044);
    endtask
    task t_msg;
        @(posedge core_clk);
        errorQueued <= 1'b1;
        operationSummary <= 1'b1;
        wr(4'h1, 4'h0, 16'h00ff);
        pulse(5'h08);
        rdChk(4'ha, 4'h0, 16'h00f4);
        @(posedge core_clk);
        errorQueued <= 1'b0;
        operationSummary <= 1'b0;
        rdChk(4'h0, 4'h0, 16'h0010);
        rdChk(4'ha, 4'h0, 16'h0044);
    endtask
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            n_fail++;
            summarize();
        end
    end
    initial
    begin
        repeat (2) @(posedge core_clk);
        srst <= 1'b0;
        t_reset();
        t_std();
        t_fault();
        t_msg();
        summarize();
    end
endmodule
`default_nettype wire
